//--- bench/twc_asserts.sv
`timescale 1ns/100ps
// ==========================================
// Link checks, watching the shared lines and the device data driver
module twc_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_ff;
  logic sda_q_ff;
  logic frame_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Frame from raw START/STOP; data edges only fall in clock low, so no filter needed
  always_ff @(posedge sys_clk) begin
    scl_q_ff <= scl;
    sda_q_ff <= sda;
    if (sys_rst) begin
      frame_ff <= 1'b0;
    end else if (scl && scl_q_ff && (sda_q_ff != sda)) begin
      frame_ff <= ~sda;
    end
  end
  idle_lines_high_a: assert property (disable iff (1'b0) sys_rst ##1 sys_rst |-> scl && sda)
    else $error("lines not released in reset");
  dev_pull_only_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data high");
  idle_clock_high_a: assert property (!frame_ff |-> scl)
    else $error("clock held low outside a frame");
  host_start_first_a: assert property ($fell(scl) |-> frame_ff)
    else $error("clock pulse outside a frame");
  dev_quiet_idle_a: assert property (!frame_ff |-> !dev_sda_oe)
    else $error("device drives data outside a frame");
  dev_after_fall_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl, 12))
    else $error("device data change not after filtered fall");
  dev_hold_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data moved while clock high");
  ack_reach_high_a: assert property ($rose(dev_sda_oe) |-> ##[1:600] ($rose(scl) && dev_sda_oe))
    else $error("device pull dropped before clock high");
  scl_high_len_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule

//--- bench/twc_bench.sv
`timescale 1ns/100ps
// ==========================================
// Host end and device end joined over one link
module twc_bench;
  import twc_pkg::*;
  localparam logic [ADDR_W-1:0] DEV = 7'h2a;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_rw = 1'b0;
  logic [ADDR_W-1:0] cmd_dev = 7'h00;
  logic [PTR_W-1:0] cmd_ptr = 8'h00;
  logic [BYTE_W-1:0] cmd_len = 8'h00;
  logic [BYTE_W-1:0] wr_data = 8'ha5;
  logic [PTR_W-1:0] usr_addr = 8'h00;
  logic byte_req, rd_valid, busy, nack, cfg_wr_stb, selected, sel_seen;
  logic [BYTE_W-1:0] rd_data, usr_data, cfg_wr_data;
  logic [PTR_W-1:0] cfg_wr_addr;
  logic [15:0] wq[$];
  logic [7:0] rq[$];
  int n_errors = 0;
  int compares = 0;
  twc_if twc_if_i ();
  twc_host_end twc_host_end_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(twc_if_i.host),
    .cmd_valid(cmd_valid), .cmd_rw(cmd_rw), .cmd_dev(cmd_dev), .cmd_ptr(cmd_ptr), .cmd_len(cmd_len),
    .wr_data(wr_data), .byte_req(byte_req), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .nack(nack));
  twc_dev_end twc_dev_end_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(twc_if_i.dev), .dev_sel(DEV),
    .usr_addr(usr_addr), .usr_data(usr_data), .cfg_wr_stb(cfg_wr_stb), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data), .selected(selected));
  twc_asserts twc_asserts_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_o(twc_if_i.scl_o),
    .scl_oe(twc_if_i.scl_oe), .host_sda_o(twc_if_i.host_sda_o), .host_sda_oe(twc_if_i.host_sda_oe),
    .dev_sda_o(twc_if_i.dev_sda_o), .dev_sda_oe(twc_if_i.dev_sda_oe), .scl(twc_if_i.scl), .sda(twc_if_i.sda));
  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;
  // First write byte goes with the command, the second follows the first request;
  // a longer burst would need a table
  always @(posedge sys_clk) begin
    if (cmd_valid === 1'b1) wr_data <= 8'ha5;
    else if (byte_req === 1'b1) wr_data <= 8'h3c;
  end
  // Record register writes, read bytes and selection
  always @(posedge sys_clk) begin
    if (cfg_wr_stb === 1'b1) wq.push_back({cfg_wr_addr, cfg_wr_data});
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (cmd_valid === 1'b1) sel_seen <= 1'b0;
    else if (selected === 1'b1) sel_seen <= 1'b1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Issue one command and wait for the transaction to finish; a hang is left to the watchdog
  task automatic run_cmd(input logic rw, input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] len);
    wq.delete();
    rq.delete();
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_rw <= rw;
    cmd_dev <= dev;
    cmd_ptr <= ptr;
    cmd_len <= len;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(posedge sys_clk) #1;
    while (busy !== 1'b0) @(posedge sys_clk) #1;
  endtask
  task automatic test_write;
    run_cmd(1'b0, DEV, 8'hff, 8'h02);
    chk(16'(wq.size()), 16'h0002);
    chk(wq[0], 16'hffa5);
    chk(wq[1], 16'h003c);
    chk(16'({nack, sel_seen}), 16'h0001);
    @(posedge sys_clk);
    usr_addr <= 8'hff;
    repeat (2) @(posedge sys_clk);
    #1 chk(16'(usr_data), 16'h00a5);
    $display("write burst done");
  endtask
  task automatic test_read;
    run_cmd(1'b1, DEV, 8'hff, 8'h02);
    chk(16'(rq.size()), 16'h0002);
    chk({rq[0], rq[1]}, 16'ha53c);
    chk({15'(wq.size()), nack}, 16'h0000);
    chk(16'({nack, sel_seen}), 16'h0001);
    $display("read burst done");
  endtask
  task automatic test_mismatch;
    run_cmd(1'b0, DEV ^ 7'h01, 8'h10, 8'h01);
    chk(16'({nack, sel_seen}), 16'h0002);
    chk(16'(wq.size()), 16'h0000);
    $display("address mismatch done");
  endtask
  task automatic conclude;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Three transfers need about 95500 cycles; a hang is cut off soon after
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk) #1;
    chk(16'({twc_if_i.scl, twc_if_i.sda, busy}), 16'h0006);
    test_write();
    test_read();
    test_mismatch();
    conclude();
  end
endmodule

//--- common/twc_if.sv
`timescale 1ns/100ps
// Two-wire link; both lines are resolved as pulled-up wired-AND
interface twc_if;
  logic scl_o;
  logic scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // ==========================================================================
  // Line resolution: a driver pulls low only when enabled and driving zero
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

  modport host (
    output scl_o,
    output scl_oe,
    output host_sda_o,
    output host_sda_oe,
    input sda
  );

  modport dev (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );
endinterface

//--- common/twc_pkg.sv
package twc_pkg;

  // ==========================================================================
  // Widths
  localparam int SYS_CLK_MHZ = 100;
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int PTR_W = 8;
  localparam int REG_DEPTH = 256;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 4'h1;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  // ==========================================================================
  // Time to cycle conversion
  // Least times round up, longest times round down, never below one cycle
  function automatic int ns_to_cyc_up(input int ns);
    int c;
    c = (ns * SYS_CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int ns_to_cyc_dn(input int ns);
    int c;
    c = (ns * SYS_CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // ==========================================================================
  // Timing
  localparam int FILT_NS = 120;
  localparam int FILT_CYC = ns_to_cyc_up(FILT_NS);
  localparam int FILT_CNT_W = $clog2(FILT_CYC + 1);
  localparam logic [FILT_CNT_W-1:0] FILT_LAST = FILT_CNT_W'(FILT_CYC - 1);
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC = ns_to_cyc_dn(SCL_PERIOD_NS / 4);
  localparam int QTR_CNT_W = $clog2(QTR_CYC + 1);
  localparam logic [QTR_CNT_W-1:0] QTR_LAST = QTR_CNT_W'(QTR_CYC - 1);

endpackage

//--- rtl/twc_dev_end.sv
`timescale 1ns/100ps
// Summary of operation
// - Idle bus leaves both lines released high
// - Host opens each transaction with START
// - Ignore everything until a START is seen
// - Host sends seven address bits plus direction
// - Acknowledge address equal to select pins
// - Any number of bytes after address
// - STOP returns the device to idle
// - Repeated START takes a fresh address byte
// - Data stable while clock high
// - Sample data on delayed clock rising edge
// - Sync and filter clock over 120ns
// - Change read data after filtered falling edge
// - Compare first seven bits; write needs zero
// - First write byte loads register pointer
// - Store data at pointer, then increment
// - Burst writes fill consecutive registers
// - Reads return pointer register, then increment
// - Data line only pulled low or released
module twc_dev_end (
  input wire logic sys_clk,
  input wire logic sys_rst,
  twc_if.dev link,
  input wire logic [twc_pkg::ADDR_W-1:0] dev_sel,
  input wire logic [twc_pkg::PTR_W-1:0] usr_addr,
  output logic [twc_pkg::BYTE_W-1:0] usr_data,
  output logic cfg_wr_stb,
  output logic [twc_pkg::PTR_W-1:0] cfg_wr_addr,
  output logic [twc_pkg::BYTE_W-1:0] cfg_wr_data,
  output logic selected
);
  import twc_pkg::*;

  typedef enum {DS_IDLE, DS_ADDR, DS_ACK, DS_WRX, DS_RTX, DS_RACK, DS_IGNORE} twc_dev_state_e;

  twc_dev_state_e state_ff;
  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic [ADDR_W-1:0] sel_sync0_ff, sel_ff;
  logic [FILT_CNT_W-1:0] scl_cnt_ff, sda_cnt_ff;
  logic scl_f_ff, sda_f_ff, scl_prev_ff, sda_prev_ff;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [BIT_CNT_W-1:0] cnt_ff;
  logic [BYTE_W-1:0] rx_sh_ff, tx_sh_ff, usr_data_ff, cfg_wr_data_ff;
  logic [PTR_W-1:0] ptr_ff, cfg_wr_addr_ff;
  logic rw_ff, ptr_loaded_ff, sda_oe_ff, cfg_wr_stb_ff, selected_ff;
  logic [BYTE_W-1:0] cfg_mem [0:REG_DEPTH-1];

  // ==========================================================================
  // Filter step: count cycles that the synced line differs from the filtered one
  function automatic logic [FILT_CNT_W-1:0] filt_next(input logic raw, input logic filt,
                                                      input logic [FILT_CNT_W-1:0] cnt);
    return (raw == filt || cnt == FILT_LAST) ? '0 : FILT_CNT_W'(cnt + 1'b1);
  endfunction

  // ==========================================================================
  // Pin synchronisers; only the second stages are looked at
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      sel_sync0_ff <= '0;
      sel_ff <= '0;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], link.scl};
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
      sel_sync0_ff <= dev_sel;
      sel_ff <= sel_sync0_ff;
    end
  end

  // Both lines get the same delay so START and STOP keep their order vs. clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_cnt_ff <= '0;
      sda_cnt_ff <= '0;
      scl_f_ff <= 1'b1;
      sda_f_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_cnt_ff <= filt_next(scl_sync_ff[1], scl_f_ff, scl_cnt_ff);
      sda_cnt_ff <= filt_next(sda_sync_ff[1], sda_f_ff, sda_cnt_ff);
      if (scl_sync_ff[1] != scl_f_ff && scl_cnt_ff == FILT_LAST) begin
        scl_f_ff <= scl_sync_ff[1];
      end
      if (sda_sync_ff[1] != sda_f_ff && sda_cnt_ff == FILT_LAST) begin
        sda_f_ff <= sda_sync_ff[1];
      end
      scl_prev_ff <= scl_f_ff;
      sda_prev_ff <= sda_f_ff;
    end
  end

  // ==========================================================================
  // Bus events on the filtered, delayed lines
  assign scl_rise = scl_f_ff & ~scl_prev_ff;
  assign scl_fall = ~scl_f_ff & scl_prev_ff;
  assign start_seen = scl_f_ff & scl_prev_ff & ~sda_f_ff & sda_prev_ff;
  assign stop_seen = scl_f_ff & scl_prev_ff & sda_f_ff & ~sda_prev_ff;

  // ==========================================================================
  // Protocol engine
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= DS_IDLE;
      cnt_ff <= BIT_CNT_ZERO;
      rx_sh_ff <= '0;
      tx_sh_ff <= '0;
      ptr_ff <= '0;
      rw_ff <= DIR_WRITE;
      ptr_loaded_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      cfg_wr_stb_ff <= 1'b0;
      cfg_wr_addr_ff <= '0;
      cfg_wr_data_ff <= '0;
      selected_ff <= 1'b0;
    end else begin
      cfg_wr_stb_ff <= 1'b0;
      if (start_seen) begin
        // Fresh or repeated START: a new address byte follows; pointer is kept
        state_ff <= DS_ADDR;
        cnt_ff <= BIT_CNT_ZERO;
        ptr_loaded_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
        selected_ff <= 1'b0;
      end else if (stop_seen) begin
        state_ff <= DS_IDLE;
        sda_oe_ff <= 1'b0;
        selected_ff <= 1'b0;
      end else begin
        case (state_ff)
          DS_ADDR, DS_WRX: begin
            if (scl_rise) begin
              rx_sh_ff <= {rx_sh_ff[BYTE_W-2:0], sda_f_ff};
              cnt_ff <= BIT_CNT_W'(cnt_ff + 1'b1);
            end else if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
              cnt_ff <= BIT_CNT_ZERO;
              if (state_ff == DS_ADDR) begin
                if (rx_sh_ff[BYTE_W-1:1] == sel_ff) begin
                  state_ff <= DS_ACK;
                  sda_oe_ff <= 1'b1;
                  rw_ff <= rx_sh_ff[0];
                  selected_ff <= 1'b1;
                end else begin
                  state_ff <= DS_IGNORE;
                end
              end else begin
                state_ff <= DS_ACK;
                sda_oe_ff <= 1'b1;
                if (!ptr_loaded_ff) begin
                  ptr_ff <= rx_sh_ff;
                  ptr_loaded_ff <= 1'b1;
                end else begin
                  cfg_wr_stb_ff <= 1'b1;
                  cfg_wr_addr_ff <= ptr_ff;
                  cfg_wr_data_ff <= rx_sh_ff;
                  ptr_ff <= PTR_W'(ptr_ff + 1'b1);
                end
              end
            end
          end
          DS_ACK: begin
            // Acknowledge ends on the filtered falling edge
            if (scl_fall) begin
              if (rw_ff == DIR_READ) begin
                state_ff <= DS_RTX;
                tx_sh_ff <= {cfg_mem[ptr_ff][BYTE_W-2:0], 1'b0};
                sda_oe_ff <= ~cfg_mem[ptr_ff][BYTE_W-1];
                cnt_ff <= BIT_CNT_ONE;
              end else begin
                state_ff <= DS_WRX;
                sda_oe_ff <= 1'b0;
              end
            end
          end
          DS_RTX: begin
            if (scl_fall) begin
              if (cnt_ff == BITS_PER_BYTE) begin
                state_ff <= DS_RACK;
                sda_oe_ff <= 1'b0;
                ptr_ff <= PTR_W'(ptr_ff + 1'b1);
              end else begin
                sda_oe_ff <= ~tx_sh_ff[BYTE_W-1];
                tx_sh_ff <= {tx_sh_ff[BYTE_W-2:0], 1'b0};
                cnt_ff <= BIT_CNT_W'(cnt_ff + 1'b1);
              end
            end
          end
          DS_RACK: begin
            if (scl_rise && sda_f_ff) begin
              state_ff <= DS_IGNORE;
            end else if (scl_fall) begin
              state_ff <= DS_RTX;
              tx_sh_ff <= {cfg_mem[ptr_ff][BYTE_W-2:0], 1'b0};
              sda_oe_ff <= ~cfg_mem[ptr_ff][BYTE_W-1];
              cnt_ff <= BIT_CNT_ONE;
            end
          end
          DS_IDLE, DS_IGNORE: sda_oe_ff <= 1'b0;
          default: begin
            state_ff <= DS_IDLE;
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Register store; not reset, so software must write a register before trusting it
  always_ff @(posedge sys_clk) begin
    if (cfg_wr_stb_ff) begin
      cfg_mem[cfg_wr_addr_ff] <= cfg_wr_data_ff;
    end
  end

  // Local read port for the rest of the chip, one cycle of latency
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      usr_data_ff <= '0;
    end else begin
      usr_data_ff <= cfg_mem[usr_addr];
    end
  end

  // ==========================================================================
  // Outputs; the data line is never driven high
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_oe_ff;
  assign usr_data = usr_data_ff;
  assign cfg_wr_stb = cfg_wr_stb_ff;
  assign cfg_wr_addr = cfg_wr_addr_ff;
  assign cfg_wr_data = cfg_wr_data_ff;
  assign selected = selected_ff;

endmodule

//--- rtl/twc_host_end.sv
`timescale 1ns/100ps
// Host end: makes the clock line from sys_clk and runs pointer write, data
// write burst, or pointer write plus repeated start plus read burst.
module twc_host_end (
  input wire logic sys_clk,
  input wire logic sys_rst,
  twc_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_rw,
  input wire logic [twc_pkg::ADDR_W-1:0] cmd_dev,
  input wire logic [twc_pkg::PTR_W-1:0] cmd_ptr,
  input wire logic [twc_pkg::BYTE_W-1:0] cmd_len,
  input wire logic [twc_pkg::BYTE_W-1:0] wr_data,
  output logic byte_req,
  output logic [twc_pkg::BYTE_W-1:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output logic nack
);
  import twc_pkg::*;

  typedef enum {HS_IDLE, HS_START, HS_BIT, HS_RSTART, HS_STOP} twc_hst_state_e;
  typedef enum {SQ_ADDR_W, SQ_PTR, SQ_WDATA, SQ_ADDR_R, SQ_RDATA} twc_seq_e;

  twc_hst_state_e state_ff;
  twc_seq_e seq_ff;
  logic [QTR_CNT_W-1:0] qcnt_ff;
  logic [1:0] ph_ff;
  logic [BIT_CNT_W-1:0] idx_ff;
  logic [BYTE_W-1:0] tx_sh_ff, rx_sh_ff, rem_ff, rd_data_ff;
  logic [ADDR_W-1:0] dev_ff;
  logic [PTR_W-1:0] ptr_ff;
  logic rw_ff, ack_ff, scl_ff, sda_oe_ff, busy_ff, nack_ff, rd_valid_ff, byte_req_ff;
  logic [1:0] sda_sync_ff;
  logic tick;

  // ==========================================================================
  // Quarter-period divider for the clock line
  assign tick = (qcnt_ff == QTR_LAST);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_ff == HS_IDLE) begin
      qcnt_ff <= '0;
    end else begin
      qcnt_ff <= tick ? '0 : QTR_CNT_W'(qcnt_ff + 1'b1);
    end
  end

  // Read-back of the data line; second stage alone feeds logic
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sda_sync_ff <= 2'h3;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
    end
  end

  // ==========================================================================
  // Sequencer: bits are set in quarter 0, clock high in 2-3, sampled end of 2
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= HS_IDLE;
      seq_ff <= SQ_ADDR_W;
      ph_ff <= 2'h0;
      idx_ff <= BIT_CNT_ZERO;
      tx_sh_ff <= '0;
      rx_sh_ff <= '0;
      rem_ff <= '0;
      dev_ff <= '0;
      ptr_ff <= '0;
      rw_ff <= 1'b0;
      ack_ff <= 1'b0;
      scl_ff <= 1'b1;
      sda_oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      nack_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      byte_req_ff <= 1'b0;
      rd_data_ff <= '0;
    end else begin
      rd_valid_ff <= 1'b0;
      byte_req_ff <= 1'b0;
      case (state_ff)
        HS_IDLE: begin
          if (cmd_valid) begin
            state_ff <= HS_START;
            busy_ff <= 1'b1;
            nack_ff <= 1'b0;
            rw_ff <= cmd_rw;
            dev_ff <= cmd_dev;
            ptr_ff <= cmd_ptr;
            rem_ff <= cmd_len;
            seq_ff <= SQ_ADDR_W;
            tx_sh_ff <= {cmd_dev, DIR_WRITE};
            ph_ff <= 2'h0;
          end
        end
        HS_START: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h0) begin
              sda_oe_ff <= 1'b1;
            end else begin
              scl_ff <= 1'b0;
              state_ff <= HS_BIT;
              idx_ff <= BIT_CNT_ZERO;
              ph_ff <= 2'h0;
            end
          end
        end
        HS_RSTART: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: sda_oe_ff <= 1'b0;
              2'h1: scl_ff <= 1'b1;
              2'h2: sda_oe_ff <= 1'b1;
              default: begin
                scl_ff <= 1'b0;
                state_ff <= HS_BIT;
                idx_ff <= BIT_CNT_ZERO;
              end
            endcase
          end
        end
        HS_STOP: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: sda_oe_ff <= 1'b1;
              2'h1: scl_ff <= 1'b1;
              2'h2: sda_oe_ff <= 1'b0;
              default: begin
                state_ff <= HS_IDLE;
                busy_ff <= 1'b0;
              end
            endcase
          end
        end
        HS_BIT: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: begin
                // Data changes only while the clock is low
                if (idx_ff != BITS_PER_BYTE) begin
                  sda_oe_ff <= (seq_ff == SQ_RDATA) ? 1'b0 : ~tx_sh_ff[BYTE_W-1];
                end else begin
                  sda_oe_ff <= (seq_ff == SQ_RDATA) && (rem_ff > 8'h01);
                end
              end
              2'h1: scl_ff <= 1'b1;
              2'h2: begin
                if (idx_ff != BITS_PER_BYTE) begin
                  rx_sh_ff <= {rx_sh_ff[BYTE_W-2:0], sda_sync_ff[1]};
                end else begin
                  ack_ff <= ~sda_sync_ff[1];
                end
              end
              default: begin
                scl_ff <= 1'b0;
                tx_sh_ff <= {tx_sh_ff[BYTE_W-2:0], 1'b0};
                idx_ff <= BIT_CNT_W'(idx_ff + 1'b1);
                if (idx_ff == BITS_PER_BYTE) begin
                  idx_ff <= BIT_CNT_ZERO;
                  if (seq_ff != SQ_RDATA && !ack_ff) begin
                    nack_ff <= 1'b1;
                    state_ff <= HS_STOP;
                  end else begin
                    case (seq_ff)
                      SQ_ADDR_W: begin
                        seq_ff <= SQ_PTR;
                        tx_sh_ff <= ptr_ff;
                      end
                      SQ_ADDR_R: seq_ff <= SQ_RDATA;
                      SQ_RDATA: begin
                        rd_data_ff <= rx_sh_ff;
                        rd_valid_ff <= 1'b1;
                        rem_ff <= rem_ff - 8'h01;
                        if (rem_ff == 8'h01) begin
                          state_ff <= HS_STOP;
                        end
                      end
                      default: begin
                        // Pointer or data byte acknowledged
                        if (seq_ff == SQ_WDATA) begin
                          rem_ff <= rem_ff - 8'h01;
                        end
                        if (rw_ff && seq_ff == SQ_PTR && rem_ff != 8'h00) begin
                          seq_ff <= SQ_ADDR_R;
                          tx_sh_ff <= {dev_ff, DIR_READ};
                          state_ff <= HS_RSTART;
                        end else if (rw_ff || rem_ff == 8'h00 || (seq_ff == SQ_WDATA && rem_ff == 8'h01)) begin
                          state_ff <= HS_STOP;
                        end else begin
                          seq_ff <= SQ_WDATA;
                          tx_sh_ff <= wr_data;
                          byte_req_ff <= 1'b1;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        default: state_ff <= HS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Outputs; the clock line is only ever pulled low or released
  assign link.scl_o = 1'b0;
  assign link.scl_oe = ~scl_ff;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_oe_ff;
  assign byte_req = byte_req_ff;
  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign busy = busy_ff;
  assign nack = nack_ff;

endmodule
